// File: logic/dpv_pkg.sv
// Register map, field layout and reset values of the pixel validity filter
package dpv_pkg;
	localparam int unsigned DW = 16;
	localparam int unsigned EW = 32;
	localparam int unsigned AW = 16;
	localparam int unsigned RW = 32;
	localparam int unsigned WHY_W = 6;

	// Register indices, used directly as addresses
	localparam logic [AW-1:0] IDX_AMP_WIN   = 16'h0028;
	localparam logic [AW-1:0] IDX_RNG_WIN   = 16'h0029;
	localparam logic [AW-1:0] IDX_SCAT      = 16'h002A;
	localparam logic [AW-1:0] IDX_ERR       = 16'h0030;
	localparam logic [AW-1:0] IDX_FEN       = 16'h0031;
	localparam logic [AW-1:0] IDX_GOFF      = 16'h0033;
	localparam logic [AW-1:0] IDX_EDGE      = 16'h0039;
	localparam logic [AW-1:0] IDX_TBLUR     = 16'h003A;
	localparam logic [AW-1:0] IDX_INTF_THR  = 16'h003B;
	localparam logic [AW-1:0] IDX_MFBLUR    = 16'h003D;
	localparam logic [AW-1:0] IDX_FW_REV    = 16'h0041;
	localparam logic [AW-1:0] IDX_NF3_SEL   = 16'h0042;
	localparam logic [AW-1:0] IDX_OFMT      = 16'h0046;
	localparam logic [AW-1:0] IDX_BOOT      = 16'h00AD;
	localparam logic [AW-1:0] IDX_INTF_AREA = 16'h0127;

	localparam logic [RW-1:0] RST_AMP_WIN  = 32'hFFFF_0000;
	localparam logic [RW-1:0] RST_RNG_WIN  = 32'hFFFF_0000;
	localparam logic [RW-1:0] RST_SCAT     = 32'h0000_0200;
	localparam logic [RW-1:0] RST_ERR      = 32'hFFFF_FFFF;
	localparam logic [RW-1:0] RST_FEN      = 32'h0DAC_000F;
	localparam logic [RW-1:0] RST_GOFF     = 32'h8000_0000;
	localparam logic [RW-1:0] RST_EDGE     = 32'h0000_FFFF;
	localparam logic [RW-1:0] RST_TBLUR    = 32'h0200_0020;
	localparam logic [RW-1:0] RST_INTF_THR = 32'h0000_0000;
	localparam logic [RW-1:0] RST_MFBLUR   = 32'hFF00_0C80;
	localparam logic [RW-1:0] RST_NF3_SEL  = 32'h0000_1D4C;
	localparam logic [RW-1:0] RST_OFMT     = 32'h1000_3032;

	// Filter enable, kernel select and boot status bit positions
	localparam int unsigned FEN_NF1  = 1;
	localparam int unsigned FEN_NF2  = 2;
	localparam int unsigned FEN_EDGE = 3;
	localparam int unsigned FEN_NF3  = 4;
	localparam int unsigned NF3_GAUSS = 31;
	localparam int unsigned BOOT_DONE = 0;

	// Reject reason bit positions
	localparam int unsigned WHY_AMP_HI = 0;
	localparam int unsigned WHY_AMP_LO = 1;
	localparam int unsigned WHY_RNG    = 2;
	localparam int unsigned WHY_SCAT   = 3;
	localparam int unsigned WHY_ERR    = 4;
	localparam int unsigned WHY_EDGE   = 5;
endpackage

// File: logic/dpv_skid.sv
// Two-entry buffer; out_valid and out_data come straight from the head register, in_ready from the spare slot
`timescale 1ns/1ps
module dpv_skid #(
	parameter int unsigned W = 8
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	typedef struct packed {
		logic         hv;
		logic [W-1:0] hd;
		logic         sv;
		logic [W-1:0] sd;
	} dpv_skid_t;

	dpv_skid_t st_q;
	dpv_skid_t st_d;

	always_comb begin
		st_d = st_q;
		if (!st_q.hv || out_ready) begin
			if (st_q.sv) begin
				st_d.hv = 1'b1;
				st_d.hd = st_q.sd;
				st_d.sv = 1'b0;
			end else begin
				st_d.hv = in_valid;
				st_d.hd = in_data;
			end
		end else if (in_valid && !st_q.sv) begin
			// Head is stalled, so the new word parks in the spare slot
			st_d.sv = 1'b1;
			st_d.sd = in_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign in_ready  = !st_q.sv;
	assign out_valid = st_q.hv;
	assign out_data  = st_q.hd;
endmodule

// File: logic/dpv_filter.sv
// Pixel validity masking stage with its control registers
//
// Behaviour
// R01: Depth becomes zero when amplitude exceeds the amplitude ceiling.
// R02: Depth becomes zero when amplitude is below the amplitude floor.
// R03: Depth becomes zero when depth exceeds the range ceiling.
// R04: Depth becomes zero when depth is below the range floor.
// R05: Depth becomes zero when scattering amplitude is below scatter threshold.
// R06: Depth becomes zero when error coefficient exceeds the 32-bit threshold.
// R07: Depth becomes zero when edge coefficient exceeds the edge threshold.
// R08: Filter enable bit 3 switches edge pixel removal; resets on.
// R09: Filter enable bit 4 switches noise stage three; resets off.
// R10: Select bit 31 picks the Gaussian kernel for noise stage three.
// R11: Filter enable bit 2 switches noise stage two; resets on.
// R12: Filter enable bit 1 switches noise stage one; resets on.
// R13: Any failed enabled test zeroes depth; otherwise depth passes unchanged.
// R14: Host keeps reserved register fields at their reset values.
`timescale 1ns/1ps
module dpv_filter
	import dpv_pkg::*;
#(
	// Arbitrary revision value, set per build
	parameter logic [RW-1:0] FW_REV = 32'h0001_0000
) (
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	input  wire logic [dpv_pkg::AW-1:0] reg_addr,
	input  wire logic [dpv_pkg::RW-1:0] reg_wdata,
	output logic [dpv_pkg::RW-1:0]     reg_rdata,
	output logic                       reg_rvalid,
	input  wire logic                  pix_valid,
	output logic                       pix_ready,
	input  wire logic [dpv_pkg::DW-1:0] pix_depth,
	input  wire logic [dpv_pkg::DW-1:0] pix_amp,
	input  wire logic [dpv_pkg::DW-1:0] pix_scat,
	input  wire logic [dpv_pkg::EW-1:0] pix_err,
	input  wire logic [dpv_pkg::DW-1:0] pix_edge,
	output logic                       out_valid,
	input  wire logic                  out_ready,
	output logic [dpv_pkg::DW-1:0]     out_depth,
	output logic [dpv_pkg::DW-1:0]     out_amp,
	output logic [dpv_pkg::WHY_W-1:0]  out_why,
	output logic                       nf1_en,
	output logic                       nf2_en,
	output logic                       nf3_en,
	output logic                       noise_stage_three_kernel_select,
	output logic                       edge_rm_en
);
	import dpv_pkg::*;

	localparam int unsigned BW = 2 * DW + WHY_W;

	typedef struct packed {
		logic [RW-1:0] amp_win;
		logic [RW-1:0] rng_win;
		logic [RW-1:0] scat;
		logic [RW-1:0] err;
		logic [RW-1:0] fen;
		logic [RW-1:0] goff;
		logic [RW-1:0] edge_thr;
		logic [RW-1:0] tblur;
		logic [RW-1:0] intf_thr;
		logic [RW-1:0] mfblur;
		logic [RW-1:0] nf3_sel;
		logic [RW-1:0] ofmt;
		logic [RW-1:0] rdata;
		logic          rvalid;
		logic          booted;
		logic          nf1;
		logic          nf2;
		logic          nf3;
		logic          gauss;
		logic          edge_rm;
	} dpv_state_t;

	dpv_state_t st_q;
	dpv_state_t st_d;

	logic              buf_ready;
	logic              buf_valid;
	logic [BW-1:0]     buf_out;
	logic [WHY_W-1:0]  why;
	logic [DW-1:0]     masked;
	logic              push;

	function automatic logic [DW-1:0] hi_half(input logic [RW-1:0] r);
		hi_half = r[RW-1:DW];
	endfunction

	function automatic logic [DW-1:0] lo_half(input logic [RW-1:0] r);
		lo_half = r[DW-1:0];
	endfunction

	// Validity tests, each independent of the others
	always_comb begin
		why = '0;
		why[WHY_AMP_HI] = pix_amp > hi_half(st_q.amp_win);    // R01
		why[WHY_AMP_LO] = pix_amp < lo_half(st_q.amp_win);    // R02
		why[WHY_RNG] = (pix_depth > hi_half(st_q.rng_win))    // R03
			|| (pix_depth < lo_half(st_q.rng_win));           // R04
		why[WHY_SCAT] = pix_scat < hi_half(st_q.scat);        // R05
		why[WHY_ERR] = pix_err > st_q.err;                    // R06
		// Edge test only counts while removal is switched on
		why[WHY_EDGE] = st_q.edge_rm
			&& (pix_edge > lo_half(st_q.edge_thr));           // R07 R08
		masked = (|why) ? '0 : pix_depth;                     // R13
	end

	assign push = pix_valid && buf_ready;

	// Register file and read port
	always_comb begin
		st_d = st_q;
		st_d.rvalid = 1'b0;
		st_d.booted = 1'b1;
		if (reg_wr) begin
			// Whole-word writes; reserved fields are the host's to keep
			unique case (reg_addr)                            // R14
				IDX_AMP_WIN:  st_d.amp_win  = reg_wdata;
				IDX_RNG_WIN:  st_d.rng_win  = reg_wdata;
				IDX_SCAT:     st_d.scat     = reg_wdata;
				IDX_ERR:      st_d.err      = reg_wdata;
				IDX_FEN:      st_d.fen      = reg_wdata;
				IDX_GOFF:     st_d.goff     = reg_wdata;
				IDX_EDGE:     st_d.edge_thr = reg_wdata;
				IDX_TBLUR:    st_d.tblur    = reg_wdata;
				IDX_INTF_THR: st_d.intf_thr = reg_wdata;
				IDX_MFBLUR:   st_d.mfblur   = reg_wdata;
				IDX_NF3_SEL:  st_d.nf3_sel  = reg_wdata;
				IDX_OFMT:     st_d.ofmt     = reg_wdata;
				default: begin
				end
			endcase
		end
		if (reg_rd) begin
			st_d.rvalid = 1'b1;
			unique case (reg_addr)
				IDX_AMP_WIN:  st_d.rdata = st_q.amp_win;
				IDX_RNG_WIN:  st_d.rdata = st_q.rng_win;
				IDX_SCAT:     st_d.rdata = st_q.scat;
				IDX_ERR:      st_d.rdata = st_q.err;
				IDX_FEN:      st_d.rdata = st_q.fen;
				IDX_GOFF:     st_d.rdata = st_q.goff;
				IDX_EDGE:     st_d.rdata = st_q.edge_thr;
				IDX_TBLUR:    st_d.rdata = st_q.tblur;
				IDX_INTF_THR: st_d.rdata = st_q.intf_thr;
				IDX_MFBLUR:   st_d.rdata = st_q.mfblur;
				IDX_NF3_SEL:  st_d.rdata = st_q.nf3_sel;
				IDX_OFMT:     st_d.rdata = st_q.ofmt;
				IDX_FW_REV:   st_d.rdata = FW_REV;
				IDX_BOOT: begin
					st_d.rdata = '0;
					st_d.rdata[BOOT_DONE] = st_q.booted;
				end
				// Interference areas are produced elsewhere
				default:      st_d.rdata = '0;
			endcase
		end
		// Enables follow the written value one cycle later
		st_d.nf1     = st_d.fen[FEN_NF1];                    // R12
		st_d.nf2     = st_d.fen[FEN_NF2];                    // R11
		st_d.nf3     = st_d.fen[FEN_NF3];                    // R09
		st_d.edge_rm = st_d.fen[FEN_EDGE];                   // R08
		st_d.gauss   = st_d.nf3_sel[NF3_GAUSS];              // R10
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q.amp_win  <= RST_AMP_WIN;
			st_q.rng_win  <= RST_RNG_WIN;
			st_q.scat     <= RST_SCAT;
			st_q.err      <= RST_ERR;
			st_q.fen      <= RST_FEN;
			st_q.goff     <= RST_GOFF;
			st_q.edge_thr <= RST_EDGE;
			st_q.tblur    <= RST_TBLUR;
			st_q.intf_thr <= RST_INTF_THR;
			st_q.mfblur   <= RST_MFBLUR;
			st_q.nf3_sel  <= RST_NF3_SEL;
			st_q.ofmt     <= RST_OFMT;
			st_q.rdata    <= '0;
			st_q.rvalid   <= 1'b0;
			st_q.booted   <= 1'b0;
			st_q.nf1      <= RST_FEN[FEN_NF1];
			st_q.nf2      <= RST_FEN[FEN_NF2];
			st_q.nf3      <= RST_FEN[FEN_NF3];
			st_q.gauss    <= RST_NF3_SEL[NF3_GAUSS];
			st_q.edge_rm  <= RST_FEN[FEN_EDGE];
		end else begin
			st_q <= st_d;
		end
	end

	// Buffer absorbs a downstream stall without losing a pixel
	dpv_skid #(
		.W (BW)
	) u_buf (
		.clk       (clk),
		.rst_n     (rst_n),
		.in_valid  (pix_valid),
		.in_ready  (buf_ready),
		.in_data   ({masked, pix_amp, why}),
		.out_valid (buf_valid),
		.out_ready (out_ready),
		.out_data  (buf_out)
	);

	assign pix_ready  = buf_ready;
	assign out_valid  = buf_valid;
	assign out_depth  = buf_out[BW-1 -: DW];
	assign out_amp    = buf_out[WHY_W +: DW];
	assign out_why    = buf_out[WHY_W-1:0];
	assign reg_rdata  = st_q.rdata;
	assign reg_rvalid = st_q.rvalid;
	assign nf1_en     = st_q.nf1;
	assign nf2_en     = st_q.nf2;
	assign nf3_en     = st_q.nf3;
	assign noise_stage_three_kernel_select = st_q.gauss;
	assign edge_rm_en = st_q.edge_rm;

	// Checks
	sequence s_fen_write;
		reg_wr && reg_addr == IDX_FEN;
	endsequence

	sequence s_head_free;
		!buf_valid || out_ready;
	endsequence

	a_amp_ceiling: assert property (@(posedge clk) disable iff (!rst_n)
		push && pix_amp > st_q.amp_win[31:16] |-> masked == '0) // R01
		else $error("amplitude above ceiling passed");

	a_amp_floor: assert property (@(posedge clk) disable iff (!rst_n)
		push && pix_amp < st_q.amp_win[15:0] |-> why[WHY_AMP_LO]) // R02
		else $error("amplitude below floor not flagged");

	a_range_high: assert property (@(posedge clk) disable iff (!rst_n)
		push && pix_depth > st_q.rng_win[31:16] |-> masked == '0) // R03
		else $error("depth above range ceiling passed");

	a_range_low: assert property (@(posedge clk) disable iff (!rst_n)
		push && pix_depth < st_q.rng_win[15:0] |-> masked == '0) // R04
		else $error("depth below range floor passed");

	a_scatter_gate: assert property (@(posedge clk) disable iff (!rst_n)
		push && pix_scat < st_q.scat[31:16] |-> masked == '0) // R05
		else $error("low scattering amplitude passed");

	a_error_gate: assert property (@(posedge clk) disable iff (!rst_n)
		push && pix_err > st_q.err |-> masked == '0) // R06
		else $error("error coefficient above threshold passed");

	a_edge_gate: assert property (@(posedge clk) disable iff (!rst_n)
		push && edge_rm_en && pix_edge > st_q.edge_thr[15:0]
		|-> masked == '0) // R07
		else $error("edge pixel passed while removal on");

	a_edge_off: assert property (@(posedge clk) disable iff (!rst_n)
		push && !edge_rm_en |-> !why[WHY_EDGE]) // R08
		else $error("edge test active while removal off");

	a_nf3_write: assert property (@(posedge clk) disable iff (!rst_n)
		s_fen_write |=> nf3_en == $past(reg_wdata[4])
		&& nf2_en == $past(reg_wdata[2])) // R09 R11
		else $error("noise stage enables did not follow write");

	a_nf1_write: assert property (@(posedge clk) disable iff (!rst_n)
		s_fen_write |=> nf1_en == $past(reg_wdata[1])) // R12
		else $error("noise stage one enable did not follow write");

	a_kernel_sel: assert property (@(posedge clk) disable iff (!rst_n)
		reg_wr && reg_addr == IDX_NF3_SEL
		|=> noise_stage_three_kernel_select == $past(reg_wdata[31])) // R10
		else $error("kernel select did not follow write");

	a_pass_clean: assert property (@(posedge clk) disable iff (!rst_n)
		(push and s_head_free) |=> out_valid
		&& (out_why != '0 || out_depth == $past(pix_depth))) // R13
		else $error("clean pixel altered or lost");

	a_read_reply: assert property (@(posedge clk) disable iff (!rst_n)
		reg_rd |=> reg_rvalid ##1 !reg_rvalid || $past(reg_rd))
		else $error("read reply not one cycle after request");
endmodule

// File: testbench/dpv_src.sv
// Pixel source model standing in for the depth engine
`timescale 1ns/1ps
module dpv_src
	import dpv_pkg::*;
(
	input  wire logic          clk,
	output logic               pix_valid,
	input  wire logic          pix_ready,
	output logic [dpv_pkg::DW-1:0] pix_depth,
	output logic [dpv_pkg::DW-1:0] pix_amp,
	output logic [dpv_pkg::DW-1:0] pix_scat,
	output logic [dpv_pkg::EW-1:0] pix_err,
	output logic [dpv_pkg::DW-1:0] pix_edge
);
	initial begin
		pix_valid = 1'b0;
		{pix_depth, pix_amp, pix_scat, pix_err, pix_edge} = '0;
	end

	// Offer one pixel, hold all fields until taken
	task automatic send(input logic [15:0] d, input logic [15:0] a,
		input logic [15:0] s, input logic [31:0] e, input logic [15:0] g);
		@(negedge clk);
		pix_valid = 1'b1;
		pix_depth = d;
		pix_amp = a;
		pix_scat = s;
		pix_err = e;
		pix_edge = g;
		do @(posedge clk); while (pix_ready !== 1'b1);
	endtask

	// Released fields flip so stale data never passes as valid
	task automatic idle();
		@(negedge clk);
		pix_valid = 1'b0;
		pix_depth = ~pix_depth;
		pix_amp = ~pix_amp;
		pix_scat = ~pix_scat;
		pix_err = ~pix_err;
		pix_edge = ~pix_edge;
	endtask
endmodule

// File: testbench/dpv_filter_tb.sv
// Self-checking bench for the pixel validity filter
`timescale 1ns/1ps
module dpv_filter_tb;
	import dpv_pkg::*;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [15:0] reg_addr = 16'h0000;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic        out_ready = 1'b1;
	logic [31:0] reg_rdata, pix_err, amp_w, rng_w, scat_w, err_w, edge_w;
	logic [15:0] pix_depth, pix_amp, pix_scat, pix_edge, out_depth, d, a, s, g;
	logic [31:0] e;
	logic [5:0]  out_why, m;
	logic [15:0] out_amp;
	logic [37:0] ex;
	logic        reg_rvalid, pix_valid, pix_ready, out_valid, edge_on;
	logic        nf1_en, nf2_en, nf3_en, ksel, edge_rm_en;
	logic [37:0] expq[$];
	int          fails = 0;
	int          total_checks = 0;
	int          cyc = 0;
	localparam logic [15:0] RA [15] = '{IDX_AMP_WIN, IDX_RNG_WIN, IDX_SCAT,
		IDX_ERR, IDX_FEN, IDX_GOFF, IDX_EDGE, IDX_TBLUR, IDX_INTF_THR,
		IDX_MFBLUR, IDX_NF3_SEL, IDX_OFMT, IDX_FW_REV, IDX_BOOT, IDX_INTF_AREA};
	localparam logic [31:0] RV [15] = '{RST_AMP_WIN, RST_RNG_WIN, RST_SCAT,
		RST_ERR, RST_FEN, RST_GOFF, RST_EDGE, RST_TBLUR, RST_INTF_THR,
		RST_MFBLUR, RST_NF3_SEL, RST_OFMT, 32'h0001_0000, 32'h0000_0001,
		32'h0000_0000};

	always #25 clk = ~clk;

	dpv_filter dut (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .pix_valid(pix_valid), .pix_ready(pix_ready),
		.pix_depth(pix_depth), .pix_amp(pix_amp), .pix_scat(pix_scat),
		.pix_err(pix_err), .pix_edge(pix_edge), .out_valid(out_valid),
		.out_ready(out_ready), .out_depth(out_depth), .out_amp(out_amp),
		.out_why(out_why), .nf1_en(nf1_en), .nf2_en(nf2_en),
		.nf3_en(nf3_en), .noise_stage_three_kernel_select(ksel),
		.edge_rm_en(edge_rm_en));

	dpv_src src (.clk(clk), .pix_valid(pix_valid), .pix_ready(pix_ready),
		.pix_depth(pix_depth), .pix_amp(pix_amp), .pix_scat(pix_scat),
		.pix_err(pix_err), .pix_edge(pix_edge));

	task automatic chk(input string nm, input logic [31:0] x,
		input logic [31:0] y);
		total_checks++;
		if (y !== x) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, x, y);
		end
	endtask

	task automatic wr(input logic [15:0] ad, input logic [31:0] dt);
		@(negedge clk);
		reg_wr = 1'b1;
		reg_addr = ad;
		reg_wdata = dt;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask

	task automatic rd(input logic [15:0] ad, input logic [31:0] x);
		@(negedge clk);
		reg_rd = 1'b1;
		reg_addr = ad;
		// Reply stands for the one cycle after the taking edge
		@(negedge clk);
		reg_rd = 1'b0;
		chk("reg_rvalid", 32'h0000_0001, {31'h0, reg_rvalid});
		chk("reg_rdata", x, reg_rdata);
	endtask

	function automatic logic [37:0] expect_pix();
		logic [5:0] w;
		w[0] = a > amp_w[31:16];
		w[1] = a < amp_w[15:0];
		w[2] = d > rng_w[31:16] || d < rng_w[15:0];
		w[3] = s < scat_w[31:16];
		w[4] = e > err_w;
		w[5] = g > edge_w[15:0] && edge_on;
		return {w, (|w) ? 16'h0000 : d, a};
	endfunction

	task automatic chk_en(input logic [4:0] x);
		chk("enables", {27'h0, x}, {27'h0, ksel, nf3_en, edge_rm_en, nf2_en,
			nf1_en});
	endtask

	// Edge reason only checked while edge removal is on
	always @(posedge clk) begin
		if (out_valid === 1'b1 && out_ready === 1'b1) begin
			ex = expq.pop_front();
			m = edge_on ? 6'h3F : 6'h1F;
			chk("out_depth", {16'h0, ex[31:16]}, {16'h0, out_depth});
			chk("out_amp", {16'h0, ex[15:0]}, {16'h0, out_amp});
			chk("out_why", {26'h0, ex[37:32] & m}, {26'h0, out_why & m});
		end
	end

	task automatic report_and_stop();
		if (fails == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			fails++;
			report_and_stop();
		end
	end

	initial begin
		{amp_w, rng_w, scat_w, err_w, edge_w} = {RST_AMP_WIN, RST_RNG_WIN,
			RST_SCAT, RST_ERR, RST_EDGE};
		edge_on = 1'b1;
		repeat (4) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		chk_en(5'h07);
		for (int i = 0; i < 15; i++) rd(RA[i], RV[i]);
		rd(16'h0050, 32'h0000_0000);
		wr(IDX_FW_REV, 32'h1234_5678);
		rd(IDX_FW_REV, 32'h0001_0000);
		for (int v = 0; v < 16; v += 5) begin
			wr(IDX_FEN, 32'h0DAC_0001 | (v << 1));
			wr(IDX_NF3_SEL, {v[0], 15'h0000, 16'h1D4C});
			chk_en({v[0], v[3:0]});
			rd(IDX_FEN, 32'h0DAC_0001 | (v << 1));
		end
		wr(IDX_FEN, RST_FEN);
		amp_w = 32'h0F00_0100;
		rng_w = 32'h0F00_0100;
		scat_w = 32'h0080_0200;
		err_w = 32'h0001_0000;
		edge_w = 32'h0000_0040;
		wr(IDX_AMP_WIN, amp_w);
		wr(IDX_RNG_WIN, rng_w);
		wr(IDX_SCAT, scat_w);
		wr(IDX_ERR, err_w);
		wr(IDX_EDGE, edge_w);
		@(negedge clk);
		out_ready = 1'b0;
		fork
			for (int i = 0; i < 10; i++) begin
				{d, a, s, e, g} = {16'h0800, 16'h0800, 16'h0100, 32'h0000_1000,
					16'h0010};
				case (i)
				1: a = 16'h0F01;
				2: a = 16'h00FF;
				3: d = 16'h0F01;
				4: d = 16'h00FF;
				5: s = 16'h007F;
				6: e = 32'h0001_0001;
				7: g = 16'h0041;
				8: {d, a, s, e, g} = {16'h0100, 16'h0F00, 16'h0080,
					32'h0001_0000, 16'h0040};
				9: {d, a} = {16'h0F00, 16'h0100};
				default: ;
				endcase
				expq.push_back(expect_pix());
				src.send(d, a, s, e, g);
			end
			begin
				repeat (6) @(negedge clk);
				chk("pix_ready", 32'h0, {31'h0, pix_ready});
				out_ready = 1'b1;
			end
		join
		// Last pixel must not be offered again
		src.idle();
		wr(IDX_FEN, 32'h0DAC_0007);
		edge_on = 1'b0;
		{d, a, s, e, g} = {16'h0800, 16'h0800, 16'h0100, 32'h0, 16'hFFFF};
		expq.push_back(expect_pix());
		src.send(d, a, s, e, g);
		src.idle();
		repeat (5) @(negedge clk);
		chk("drained", 32'h0, expq.size());
		report_and_stop();
	end
endmodule
